/* File: verilog/sfd_core.v */
`timescale 1ns/100ps
`include "sfd_map.vh"
module sfd_core #(
  parameter AW = `SFD_ADDR_W,
  parameter PROG_CYC = `SFD_PROG_CYC
) (
  input wire clock,
  input wire reset_n,
  input wire cs_n,
  input wire sck,
  input wire serial_in,
  output reg serial_out,
  output reg serial_out_oe,
  input wire bidir_data_line_in,
  output reg bidir_data_line_out,
  output reg bidir_data_line_oe,
  input wire [15:0] sector_protect,
  input wire [15:0] sector_locked,
  output wire busy,
  output wire write_enable_latch,
  output wire program_erase_error_flag
);
  localparam S_IDLE = 4'b0001;
  localparam S_CMD = 4'b0010;
  localparam S_PROG = 4'b0100;
  localparam S_DRAIN = 4'b1000;

  reg [3:0] state_q;
  reg [7:0] sh_q;
  reg [2:0] bit_q;
  reg [7:0] op_q;
  reg [2:0] nbyte_q;
  reg [23:0] addr_q;
  reg [8:0] count_q;
  reg [7:0] off_q;
  reg [7:0] page_q [0:255];
  reg [255:0] valid_q;
  reg [7:0] dout_q;
  reg [1:0] dphase_q;
  reg wel_q;
  reg epe_q;
  reg [8:0] scan_q;
  reg [31:0] tim_q;
  reg cs_last_q;
  wire rise;
  wire fall;
  wire [AW-1:0] rd_addr;
  wire [7:0] rd_data;
  reg wr_en;
  wire wr_fail;
  wire dual_in;
  wire dual_rd;
  wire [2:0] step;
  wire [7:0] sh_next;
  wire byte_done;
  wire cs_end;
  wire aligned;
  wire take_data;
  wire buf_wr;
  wire short_frame;
  wire sect_blocked;
  wire prog_abort;
  wire [AW-1:0] prog_addr;
  wire [7:0] prog_data;

  sfd_edge u_edge (
    .clock(clock),
    .reset_n(reset_n),
    .level(sck),
    .rise(rise),
    .fall(fall)
  );

  sfd_array #(.AW(AW)) u_array (
    .clock(clock),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_addr(prog_addr),
    .wr_data(prog_data),
    .wr_fail(wr_fail)
  );

  // dual input only for data phase
  assign dual_in = (op_q == `SFD_OP_DUAL_PROG) && (nbyte_q == 3'd4);
  // dual output after opcode, address, dummy
  assign dual_rd = (op_q == `SFD_OP_DUAL_READ) && (nbyte_q == 3'd5);
  assign step = dual_in ? 3'd2 : 3'd1;
  // bidir line carries the higher bit
  assign sh_next = dual_in ? {sh_q[5:0], bidir_data_line_in, serial_in} : {sh_q[6:0], serial_in};
  assign byte_done = rise && !dual_rd && ((bit_q + step) == 4'd8 || (bit_q + step) == 3'd0);
  assign cs_end = cs_n && !cs_last_q && state_q == S_CMD;
  assign aligned = bit_q == 3'd0;
  assign busy = state_q == S_PROG;
  assign write_enable_latch = wel_q;
  assign program_erase_error_flag = epe_q;
  // counter wraps naturally at the array top
  assign rd_addr = addr_q[AW-1:0];

  function prog_op;
    input [7:0] op;
    prog_op = op == `SFD_OP_PROG || op == `SFD_OP_DUAL_PROG;
  endfunction

  // one flag per 64 KB sector, picked by the top address bits
  function sect_hit;
    input [15:0] mask;
    input [23:0] addr;
    begin
      sect_hit = mask[addr[AW-1:AW-`SFD_SECT_W]];
    end
  endfunction

  // one bit of the current output pair
  function pick;
    input [7:0] data;
    input [1:0] phase;
    input upper;
    begin
      pick = upper ? data[7 - 2*phase] : data[6 - 2*phase];
    end
  endfunction

  // wrap from the top location to zero with no extra cycle
  function [23:0] next_addr;
    input [23:0] a;
    begin
      next_addr = {{(24-AW){1'b0}}, a[AW-1:0] + {{(AW-1){1'b0}}, 1'b1}};
    end
  endfunction

  // data bytes of a program command go to the page buffer
  assign take_data = nbyte_q == 3'd4 && prog_op(op_q);
  assign buf_wr = state_q == S_CMD && !cs_n && byte_done && take_data;
  // short address, no full data byte or ragged release
  assign short_frame = nbyte_q < 3'd4 || count_q == 9'h000 || !aligned;
  // start address in a protected or locked sector
  assign sect_blocked = sect_hit(sector_protect, addr_q) || sect_hit(sector_locked, addr_q);
  assign prog_abort = short_frame || sect_blocked;
  assign prog_addr = {addr_q[AW-1:8], scan_q[7:0]};
  assign prog_data = page_q[scan_q[7:0]];

  always @* begin
    wr_en = state_q == S_PROG && !scan_q[8] && valid_q[scan_q[7:0]];
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      sh_q <= 8'h00;
      bit_q <= 3'd0;
      op_q <= 8'h00;
      nbyte_q <= 3'd0;
      addr_q <= 24'h000000;
      count_q <= 9'h000;
      off_q <= 8'h00;
      valid_q <= 256'd0;
      dout_q <= 8'h00;
      dphase_q <= 2'd0;
      wel_q <= 1'b0;
      epe_q <= 1'b0;
      scan_q <= 9'h000;
      tim_q <= 32'h00000000;
      cs_last_q <= 1'b1;
    end else begin
      cs_last_q <= cs_n;
      case (state_q)
        S_IDLE: begin
          if (!cs_n) begin
            state_q <= S_CMD;
            bit_q <= 3'd0;
            nbyte_q <= 3'd0;
            count_q <= 9'h000;
            valid_q <= 256'd0;
            dphase_q <= 2'd0;
          end
        end
        S_CMD: begin
          if (cs_end) begin
            state_q <= S_IDLE;
            if (op_q == `SFD_OP_WREN && nbyte_q == 3'd1 && aligned) begin
              wel_q <= 1'b1;
            end
            if (prog_op(op_q) && nbyte_q != 3'd0) begin
              if (prog_abort) begin
                wel_q <= 1'b0;
              end else if (wel_q) begin
                state_q <= S_PROG;
                scan_q <= 9'h000;
                tim_q <= 32'h00000000;
              end
            end
          end else begin
            if (rise && !dual_rd) begin
              sh_q <= sh_next;
              bit_q <= bit_q + step;
            end
            if (byte_done) begin
              if (nbyte_q == 3'd0) begin
                op_q <= sh_next;
              end else if (nbyte_q < 3'd4) begin
                addr_q <= {addr_q[15:0], sh_next};
                off_q <= sh_next;
              end
              // saturate so a long frame never wraps back to the opcode slot
              if (!take_data && nbyte_q != 3'd7) begin
                nbyte_q <= nbyte_q + 3'd1;
              end
              // wrap in page, last 256 kept
              if (take_data) begin
                valid_q[off_q] <= 1'b1;
                off_q <= off_q + 8'd1;
                if (!count_q[8]) count_q <= count_q + 9'd1;
              end
              if (op_q == `SFD_OP_DUAL_READ && nbyte_q == 3'd4) begin
                dout_q <= rd_data;
                addr_q <= next_addr(addr_q);
              end
            end
            // pairs advance on falling edge, MSB pair first
            if (fall && dual_rd) begin
              dphase_q <= dphase_q + 2'd1;
              if (dphase_q == 2'd3) begin
                // next byte ready with no gap
                dout_q <= rd_data;
                addr_q <= next_addr(addr_q);
              end
            end
          end
        end
        S_PROG: begin
          // only sent offsets written; others stay erased
          if (!scan_q[8]) scan_q <= scan_q + 9'd1;
          if (wr_fail) epe_q <= 1'b1;
          tim_q <= tim_q + 32'd1;
          // busy until page scan and timer both done; latch cleared on the clock busy ends
          if (scan_q[8] && tim_q >= PROG_CYC) begin
            wel_q <= 1'b0;
            state_q <= S_DRAIN;
          end
        end
        S_DRAIN: begin
          if (wr_fail) epe_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // page buffer has no reset; stale bytes are masked by valid_q
  always @(posedge clock) begin
    if (buf_wr) begin
      page_q[off_q] <= sh_next;
    end
  end

  // both lines float the clock after release, at any bit
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
      bidir_data_line_out <= 1'b0;
      bidir_data_line_oe <= 1'b0;
    end else if (state_q != S_CMD || cs_n) begin
      serial_out_oe <= 1'b0;
      bidir_data_line_oe <= 1'b0;
    end else if (fall && dual_rd) begin
      // bit 7 on serial-out, bit 6 on the two-way line
      serial_out_oe <= 1'b1;
      bidir_data_line_oe <= 1'b1;
      serial_out <= pick(dout_q, dphase_q, 1'b1);
      bidir_data_line_out <= pick(dout_q, dphase_q, 1'b0);
    end
  end
endmodule // sfd_core

/* File: verilog/sfd_map.vh */
// Overview of operation
// - dual read: opcode 3Bh, three address bytes, one dummy byte, then data.
// - dual read data two bits per clock, MSB first, new byte every four clocks.
// - first dual clock: bit 7 on serial-out, bit 6 on bidir line.
// - read address wraps from top location to zero with no extra cycles.
// - chip select release at any bit ends read and floats both outputs.
// - single program: opcode 02h, three address bytes, data into page buffer.
// - program data at successive page offsets, wrapping within the 256-byte page.
// - more than 256 data bytes: only the last 256 are kept.
// - on release, program buffered bytes; unsent page locations stay FFh.
// - abort without full address, a full data byte, and byte-aligned release.
// - protected or locked start sector: skip program, return idle.
// - any program abort clears the write-enable latch.
// - busy during self-timed program; latch cleared on the same clock that busy falls.
// - byte that fails to program sets the program/erase error flag.
// - dual program: opcode A2h, three address bytes, data two bits per clock.
// - dual program first clock: bit 7 on bidir line, bit 6 on serial-in.
// - opcode 06h alone, byte-aligned release, sets the write-enable latch.
`ifndef SFD_MAP_VH
`define SFD_MAP_VH
`define SFD_OP_DUAL_READ 8'h3b
`define SFD_OP_PROG 8'h02
`define SFD_OP_DUAL_PROG 8'ha2
`define SFD_OP_WREN 8'h06
`define SFD_ERASED 8'hff
`define SFD_ADDR_W 20
`define SFD_SECT_W 4
`define SFD_PROG_NS 1000
`define SFD_CLK_NS 100
`define SFD_PROG_CYC ((`SFD_PROG_NS + `SFD_CLK_NS - 1) / `SFD_CLK_NS)
`endif

/* File: verilog/sfd_edge.v */
`timescale 1ns/100ps
// synchronous edge finder on a sampled serial clock
module sfd_edge (
  input wire clock,
  input wire reset_n,
  input wire level,
  output wire rise,
  output wire fall
);
  reg last_q;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      last_q <= 1'b0;
    end else begin
      last_q <= level;
    end
  end
  assign rise = level & ~last_q;
  assign fall = ~level & last_q;
endmodule // sfd_edge

/* File: verilog/sfd_array.v */
`timescale 1ns/100ps
`include "sfd_map.vh"
// flash array model: program only clears bits, erased reads FFh
module sfd_array #(
  parameter AW = `SFD_ADDR_W
) (
  input wire clock,
  input wire [AW-1:0] rd_addr,
  output reg [7:0] rd_data,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  output reg wr_fail
);
  reg [7:0] mem [0:(1<<AW)-1];
  integer i;
  initial begin
    for (i = 0; i < (1<<AW); i = i + 1) mem[i] = `SFD_ERASED;
  end
  always @(posedge clock) begin
    rd_data <= mem[rd_addr];
    wr_fail <= 1'b0;
    if (wr_en) begin
      mem[wr_addr] <= mem[wr_addr] & wr_data;
      // a 0 that should become 1 cannot be programmed
      wr_fail <= |(wr_data & ~mem[wr_addr]);
    end
  end
endmodule // sfd_array

/* File: testbench/sfd_core_sva.sv */
`timescale 1ns/100ps
module sfd_core_sva #(
  parameter PROG_CYC = 10
) (
  input wire clock,
  input wire reset_n,
  input wire cs_n,
  input wire sck,
  input wire serial_out,
  input wire serial_out_oe,
  input wire bidir_data_line_oe,
  input wire busy,
  input wire write_enable_latch,
  input wire program_erase_error_flag
);
  reg [15:0] bc_q;
  always @(posedge clock or negedge reset_n)
    if (!reset_n) bc_q <= 16'h0000;
    else bc_q <= busy ? bc_q + 16'h0001 : 16'h0000;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence go_s; $rose(busy); endsequence
  sequence done_s; $fell(busy); endsequence
  float_a: assert property (cs_n [*3] |-> !serial_out_oe && !bidir_data_line_oe)
    else $error("outputs not floated");
  pair_oe_a: assert property (serial_out_oe |-> bidir_data_line_oe)
    else $error("dual lines not driven together");
  busy_quiet_a: assert property (busy |-> !serial_out_oe)
    else $error("read driven while busy");
  wel_drop_a: assert property (done_s |-> !write_enable_latch)
    else $error("latch still set after program");
  needs_wel_a: assert property (go_s |-> $past(write_enable_latch) && cs_n)
    else $error("program without latch");
  busy_len_a: assert property (bc_q <= PROG_CYC + 300)
    else $error("busy too long");
  err_hold_a: assert property (program_erase_error_flag |=> program_erase_error_flag)
    else $error("error flag dropped");
  err_cause_a: assert property ($rose(program_erase_error_flag) |-> $past(busy))
    else $error("error flag outside program");
  wel_set_a: assert property ($rose(write_enable_latch) |-> cs_n && !busy)
    else $error("latch set inside frame");
  out_edge_a: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> !sck)
    else $error("data moved while clock high");
endmodule // sfd_core_sva
bind sfd_core sfd_core_sva #(.PROG_CYC(PROG_CYC)) u_sva (.clock(clock), .reset_n(reset_n), .cs_n(cs_n),
  .sck(sck), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .bidir_data_line_oe(bidir_data_line_oe),
  .busy(busy), .write_enable_latch(write_enable_latch), .program_erase_error_flag(program_erase_error_flag));

/* File: testbench/sfd_host.sv */
`timescale 1ns/100ps
module sfd_host (
  input wire clock,
  output reg cs_n,
  output reg sck,
  output reg si,
  output reg bd
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    bd = 1'b0;
  end
  // released lines toggle so stale data never looks valid
  always @(posedge clock)
    if (cs_n) begin
      si <= ~si;
      bd <= ~bd;
    end
  task go;
    @(posedge clock) cs_n <= 1'b0;
  endtask
  task bit2(input a, input b);
    begin
      @(posedge clock);
      sck <= 1'b0;
      bd <= a;
      si <= b;
      repeat (4) @(posedge clock);
      sck <= 1'b1;
      repeat (3) @(posedge clock);
    end
  endtask
  task byte1(input [7:0] b, input dual);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - (dual ? 2 : 1))
        bit2(dual ? b[i] : ~bd, dual ? b[i - 1] : b[i]);
    end
  endtask
  task stop;
    begin
      @(posedge clock);
      sck <= 1'b0;
      repeat (4) @(posedge clock);
      cs_n <= 1'b1;
      repeat (6) @(posedge clock);
    end
  endtask
endmodule // sfd_host

/* File: testbench/tb.sv */
`timescale 1ns/100ps
`include "sfd_map.vh"
module tb;
  reg clock = 1'b0;
  reg reset_n = 1'b0;
  reg [15:0] sector_protect = 16'h0000;
  reg [15:0] sector_locked = 16'h0000;
  wire cs_n, sck, h_si, h_bd, serial_out, serial_out_oe, bidir_data_line_out, bidir_data_line_oe;
  wire busy, write_enable_latch, program_erase_error_flag;
  wire bdl = bidir_data_line_oe ? bidir_data_line_out : h_bd;
  integer err_total = 0, check_count = 0, seed = 32'hd63a6336, cyc = 0, i, n = 0;
  reg [7:0] sh, d [0:2];
  reg [7:0] q [$];
  reg [3:0] s;
  reg ps = 1'b0;
  always #50 clock = ~clock;
  sfd_host host (.clock(clock), .cs_n(cs_n), .sck(sck), .si(h_si), .bd(h_bd));
  sfd_core dut (.clock(clock), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .serial_in(h_si),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .bidir_data_line_in(bdl),
    .bidir_data_line_out(bidir_data_line_out), .bidir_data_line_oe(bidir_data_line_oe),
    .sector_protect(sector_protect), .sector_locked(sector_locked), .busy(busy),
    .write_enable_latch(write_enable_latch), .program_erase_error_flag(program_erase_error_flag));
  task ck(input string nm, input [7:0] e, input [7:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      finish_test;
    end
  end
  // read monitor: pops the oldest expected byte per four rising clocks
  always @(posedge clock) begin
    ps <= sck;
    if (cs_n) n = 0;
    else if (sck && !ps && serial_out_oe) begin
      sh = {sh[5:0], serial_out, bidir_data_line_out};
      n = n + 1;
      if (n == 4) begin
        n = 0;
        ck("read", q.pop_front(), sh);
      end
    end
  end
  task cmd(input [7:0] op, input [23:0] a);
    begin
      host.go;
      host.byte1(op, 1'b0);
      host.byte1(a[23:16], 1'b0);
      host.byte1(a[15:8], 1'b0);
      host.byte1(a[7:0], 1'b0);
    end
  endtask
  task wren;
    begin
      host.go;
      host.byte1(`SFD_OP_WREN, 1'b0);
      host.stop;
      ck("wel", 1, write_enable_latch);
    end
  endtask
  task tail(input eb);
    integer j;
    begin
      host.stop;
      ck("busy", eb, busy);
      for (j = 0; j < 3000 && busy !== 1'b0; j = j + 1) @(posedge clock);
      ck("busy", 0, busy);
      ck("wel", 0, write_enable_latch);
    end
  endtask
  task prog(input [7:0] op, input [23:0] a, input integer k, input dual);
    integer j;
    begin
      wren;
      cmd(op, a);
      for (j = 0; j < k; j = j + 1) host.byte1(d[j % 3], dual);
      tail(1'b1);
    end
  endtask
  // release lands mid-byte so the read must end without a whole byte
  task rd(input [23:0] a, input integer k);
    begin
      cmd(`SFD_OP_DUAL_READ, a);
      host.byte1(8'($random(seed)), 1'b0);
      repeat (k) host.byte1(8'($random(seed)), 1'b1);
      host.bit2(1'b0, 1'b0);
      host.stop;
      ck("left", 0, 8'(q.size()));
    end
  endtask
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    ck("wel", 0, write_enable_latch);
    for (i = 0; i < 3; i = i + 1) d[i] = 8'($random(seed));
    prog(`SFD_OP_PROG, 24'h0000fe, 3, 1'b0);
    q = {8'hff, d[2], 8'hff};
    rd(24'h0fffff, 3);
    q = {8'hff, d[0], d[1], 8'hff};
    rd(24'h0000fd, 4);
    prog(`SFD_OP_DUAL_PROG, 24'h020000, 258, 1'b1);
    q = {d[1], d[2], d[2]};
    rd(24'h020000, 3);
    for (i = 0; i < 2; i = i + 1) begin
      wren;
      if (i == 1) cmd(`SFD_OP_PROG, 24'h000040);
      else begin
        host.go;
        host.byte1(`SFD_OP_PROG, 1'b0);
      end
      host.bit2(1'b0, 1'b0);
      tail(1'b0);
    end
    q = {8'hff};
    rd(24'h000040, 1);
    s = 4'($random(seed));
    for (i = 0; i < 3; i = i + 1) begin
      sector_protect <= (i == 0) ? 16'h0001 << s : 16'h0000;
      sector_locked <= (i == 1) ? 16'h0001 << s : 16'h0000;
      if (i < 2) wren;
      cmd(`SFD_OP_PROG, {4'h0, s, 16'h0080});
      host.byte1(8'h00, 1'b0);
      tail(1'b0);
    end
    q = {8'hff};
    rd({4'h0, s, 16'h0080}, 1);
    d[0] = 8'h00;
    prog(`SFD_OP_PROG, 24'h000080, 1, 1'b0);
    ck("err", 0, program_erase_error_flag);
    d[0] = 8'hff;
    prog(`SFD_OP_PROG, 24'h000080, 1, 1'b0);
    ck("err", 1, program_erase_error_flag);
    finish_test;
  end
endmodule // tb
